// [hdl/byte_port.v]
// Eight-bit general-purpose port with per-nibble timed output transfer
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "byte_port_map.vh"

module byte_port (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Register port
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  // Timer outputs used as transfer events
  input wire timerA1,
  input wire timerB1,
  input wire timerB2,
  // Modulator outputs
  input wire [3:0] modulatorOut,
  // Serial clocks
  input wire serialCClkMode,
  input wire serialCClkInternal,
  input wire serialCClockOut,
  input wire serialDClkMode,
  input wire serialDClkInternal,
  input wire serialDClockOut,
  output reg serialCClockIn,
  output reg serialDClockIn,
  // Decoder and capture inputs
  output reg [1:0] decoder1Phase,
  output reg [1:0] decoder2Phase,
  output reg [1:0] altDecoder1Phase,
  output reg [1:0] altDecoder2Phase,
  output reg [3:0] captureIn,
  // Pins
  input wire [7:0] pinIn,
  output reg [7:0] pinOut,
  output reg [7:0] pinOe
);

  // Register state
  reg [7:0] directionReg_r;
  reg [7:0] edgeSelReg_r;
  reg [7:0] altFuncReg_r;
  reg [7:0] driveTypeReg_r;
  reg [7:0] preload_r;
  reg [7:0] outReg_r;
  reg halfClk_r;
  reg [2:0] timerDly_r;

  // Transfer events and next values
  reg loEdge;
  reg hiEdge;
  reg [7:0] rdata_nxt;
  wire [7:0] pinOut_nxt;
  wire [7:0] pinOe_nxt;
  wire [2:0] timerNow;
  wire [2:0] timerRise;
  wire halfRise;

  // Register decodes
  wire wrData;
  wire wrEdgeSel;
  wire wrAltFunc;
  wire wrDriveType;
  wire wrDirection;
  wire rdData;

  assign wrData = regWr && (regAddr == `ADDR_DATA);
  assign wrEdgeSel = regWr && (regAddr == `ADDR_EDGE_SEL);
  assign wrAltFunc = regWr && (regAddr == `ADDR_ALT_FUNC);
  assign wrDriveType = regWr && (regAddr == `ADDR_DRIVE_TYPE);
  assign wrDirection = regWr && (regAddr == `ADDR_DIRECTION);
  assign rdData = regRd && (regAddr == `ADDR_DATA);

  // Timer rising edges seen against the previous cycle
  assign timerNow = {timerB2, timerB1, timerA1};
  assign timerRise = timerNow & ~timerDly_r;
  assign halfRise = (halfClk_r == 1'b0);

  // Lower nibble event source
  always @* begin
    case (edgeSelReg_r[`SEL_LO_MSB:`SEL_LO_LSB])
      `SRC_HALF_CLK: begin
        loEdge = halfRise;
      end
      `SRC_TIMER_A1: begin
        loEdge = timerRise[0];
      end
      `SRC_TIMER_B1: begin
        loEdge = timerRise[1];
      end
      `SRC_TIMER_B2: begin
        loEdge = timerRise[2];
      end
      default: begin
        loEdge = halfRise;
      end
    endcase
  end

  // Upper nibble event source, independent of the lower one
  always @* begin
    case (edgeSelReg_r[`SEL_HI_MSB:`SEL_HI_LSB])
      `SRC_HALF_CLK: begin
        hiEdge = halfRise;
      end
      `SRC_TIMER_A1: begin
        hiEdge = timerRise[0];
      end
      `SRC_TIMER_B1: begin
        hiEdge = timerRise[1];
      end
      `SRC_TIMER_B2: begin
        hiEdge = timerRise[2];
      end
      default: begin
        hiEdge = halfRise;
      end
    endcase
  end

  // Direction, all inputs after reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      directionReg_r <= `RST_DIRECTION;
    end else if (wrDirection) begin
      directionReg_r <= regWdata;
    end
  end

  // Edge select; cleared so data moves on the half clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeSelReg_r <= `RST_EDGE_SEL;
    end else if (wrEdgeSel) begin
      edgeSelReg_r <= regWdata;
    end
  end

  // Preload, alternate function, drive type: no reset
  always @(posedge clk) begin
    if (wrData) begin
      preload_r <= regWdata;
    end
  end

  always @(posedge clk) begin
    if (wrAltFunc) begin
      altFuncReg_r <= regWdata;
    end
  end

  always @(posedge clk) begin
    if (wrDriveType) begin
      driveTypeReg_r <= regWdata;
    end
  end

  // Half-rate divider
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halfClk_r <= 1'b0;
    end else begin
      halfClk_r <= halfClk_r ^ `HALF_CLK_DIV;
    end
  end

  // Timer edge history
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerDly_r <= 3'h0;
    end else begin
      timerDly_r <= timerNow;
    end
  end

  // Lower nibble transfer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outReg_r[3:0] <= `RST_OTHER_LO;
    end else if (loEdge) begin
      outReg_r[3:0] <= preload_r[3:0];
    end
  end

  // Upper nibble transfer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outReg_r[7:4] <= `RST_OTHER_HI;
    end else if (hiEdge) begin
      outReg_r[7:4] <= preload_r[7:4];
    end
  end

  // Pin drive per bit
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      wire modSel;
      wire modVal;
      wire serialMode;
      wire serialInt;
      wire serialClk;
      reg bitDrv;
      reg bitOut;
      reg bitPin;
      reg bitOe;

      if (i >= 4) begin : g_mod
        assign modSel = altFuncReg_r[i];
        assign modVal = modulatorOut[i - 4];
      end else begin : g_nomod
        assign modSel = 1'b0;
        assign modVal = 1'b0;
      end

      if (i == 1) begin : g_ser_c
        assign serialMode = serialCClkMode;
        assign serialInt = serialCClkInternal;
        assign serialClk = serialCClockOut;
      end else if (i == 0) begin : g_ser_d
        assign serialMode = serialDClkMode;
        assign serialInt = serialDClkInternal;
        assign serialClk = serialDClockOut;
      end else begin : g_ser_none
        assign serialMode = 1'b0;
        assign serialInt = 1'b0;
        assign serialClk = 1'b0;
      end

      // Internal serial clock overrides direction and function
      always @* begin
        bitDrv = outReg_r[i];
        bitOut = directionReg_r[i];
        if (modSel) begin
          bitDrv = modVal;
        end
        if (serialMode && altFuncReg_r[i]) begin
          bitDrv = serialClk;
        end
        if (serialMode && serialInt) begin
          bitDrv = serialClk;
          bitOut = 1'b1;
        end
      end

      // Open drain only ever pulls low
      always @* begin
        if (driveTypeReg_r[i]) begin
          bitPin = 1'b0;
          bitOe = bitOut & ~bitDrv;
        end else begin
          bitPin = bitDrv;
          bitOe = bitOut;
        end
      end

      assign pinOut_nxt[i] = bitPin;
      assign pinOe_nxt[i] = bitOe;
    end
  endgenerate

  // Read data, zero outside the answer cycle
  always @* begin
    rdata_nxt = 8'h00;
    if (rdData) begin
      rdata_nxt = pinIn;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 8'h00;
    end else begin
      pinOut <= pinOut_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= 8'h00;
    end else begin
      pinOe <= pinOe_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= rdata_nxt;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialCClockIn <= 1'b0;
    end else begin
      serialCClockIn <= pinIn[1];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialDClockIn <= 1'b0;
    end else begin
      serialDClockIn <= pinIn[0];
    end
  end

  // Decoder phase taps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decoder1Phase <= 2'h0;
      decoder2Phase <= 2'h0;
      altDecoder1Phase <= 2'h0;
      altDecoder2Phase <= 2'h0;
    end else begin
      decoder1Phase <= {pinIn[1], pinIn[0]};
      decoder2Phase <= {pinIn[3], pinIn[2]};
      altDecoder1Phase <= {pinIn[5], pinIn[4]};
      altDecoder2Phase <= {pinIn[7], pinIn[6]};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captureIn <= 4'h0;
    end else begin
      captureIn <= {pinIn[7], pinIn[5], pinIn[3], pinIn[1]};
    end
  end

endmodule

// [hdl/byte_port_map.vh]
// Register offsets, field positions and reset values of the byte port
`ifndef BYTE_PORT_MAP_VH
`define BYTE_PORT_MAP_VH
`define ADDR_DATA 8'h38
`define ADDR_EDGE_SEL 8'h3c
`define ADDR_ALT_FUNC 8'h3d
`define ADDR_DRIVE_TYPE 8'h3e
`define ADDR_DIRECTION 8'h3f
`define SEL_LO_MSB 1
`define SEL_LO_LSB 0
`define SEL_HI_MSB 5
`define SEL_HI_LSB 4
`define SRC_HALF_CLK 2'h0
`define SRC_TIMER_A1 2'h1
`define SRC_TIMER_B1 2'h2
`define SRC_TIMER_B2 2'h3
`define RST_DIRECTION 8'h00
`define RST_EDGE_SEL 8'h00
`define RST_OTHER 8'h00
`define RST_OTHER_LO 4'h0
`define RST_OTHER_HI 4'h0
`define HALF_CLK_DIV 1'b1
`endif

// [testbench/byte_port_asserts.sv]
// Checker of the byte port
`timescale 1ns/1ns
module byte_port_asserts (
  // Clock, reset, bus
  input wire clk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire regRd,
  input wire [7:0] regRdata,
  // Pins, taps, serial
  input wire [7:0] pinIn,
  input wire [7:0] pinOe,
  input wire [3:0] captureIn,
  input wire [1:0] decoder1Phase,
  input wire [1:0] decoder2Phase,
  input wire [1:0] altDecoder1Phase,
  input wire [1:0] altDecoder2Phase,
  input wire serialCClockIn,
  input wire serialDClockIn,
  input wire serialCClkMode,
  input wire serialCClkInternal,
  input wire serialCClockOut
);
  reg [7:0] pinPrev;
  reg armC;
  always @(posedge clk) begin
    pinPrev <= pinIn;
    armC <= rst_n & serialCClkMode & serialCClkInternal & ~serialCClockOut;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rd_pins: assert property ($past(regRd) && $past(regAddr) == 8'h38 |->
    regRdata == pinPrev) else $error("read data");
  a_rd_zero: assert property (!$past(regRd) || $past(regAddr) != 8'h38 |->
    regRdata == 8'h00) else $error("idle read data");
  a_rst_oe: assert property (disable iff (1'b0) !rst_n |-> pinOe == 8'h00)
    else $error("drive in reset");
  a_cap_map: assert property ($past(rst_n) |->
    captureIn == {pinPrev[7], pinPrev[5], pinPrev[3], pinPrev[1]}) else $error("capture");
  a_dec_one: assert property ($past(rst_n) |-> decoder1Phase == pinPrev[1:0])
    else $error("decoder1");
  a_dec_alt: assert property ($past(rst_n) |-> altDecoder2Phase == pinPrev[7:6])
    else $error("alt decoder2");
  a_ser_in: assert property ($past(rst_n) |-> serialCClockIn == pinPrev[1])
    else $error("serial clock in");
  a_ser_d_in: assert property ($past(rst_n) |-> serialDClockIn == pinPrev[0])
    else $error("serial d clock in");
  a_dec_two: assert property ($past(rst_n) |-> decoder2Phase == pinPrev[3:2])
    else $error("decoder2");
  a_dec_alt_one: assert property ($past(rst_n) |-> altDecoder1Phase == pinPrev[5:4])
    else $error("alt decoder1");
  a_clk_out: assert property (armC |-> pinOe[1])
    else $error("serial clock drive");
endmodule
bind byte_port byte_port_asserts chk (.*);

// [testbench/pin_world.sv]
// Circuitry outside the pins
`timescale 1ns/1ns
module pin_world (
  // Port drive
  input wire [7:0] pinOut,
  input wire [7:0] pinOe,
  // Outside level
  input wire [7:0] extLevel,
  // Seen at the pins
  output wire [7:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// [testbench/tb_top.sv]
// Bench for the byte port
`timescale 1ns/1ns
`include "byte_port_map.vh"
module tb_top;
  reg clk = 1'b0, rst_n = 1'b1, regWr = 1'b0, regRd = 1'b0, sMode = 1'b0, sInt = 1'b0;
  reg [2:0] tmr = 3'h0;
  reg [7:0] regAddr = 8'h00, regWdata = 8'h00;
  wire [7:0] regRdata, pinIn, pinOut, pinOe;
  integer n_errors = 0, comparisons = 0;
  initial forever #2 clk = ~clk;
  byte_port dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .timerA1(tmr[0]), .timerB1(tmr[1]), .timerB2(tmr[2]), .modulatorOut(4'h9),
    .serialCClkMode(sMode), .serialCClkInternal(sInt), .serialCClockOut(1'b0),
    .serialDClkMode(sMode), .serialDClkInternal(sInt), .serialDClockOut(1'b0),
    .serialCClockIn(), .serialDClockIn(), .decoder1Phase(), .decoder2Phase(),
    .altDecoder1Phase(), .altDecoder2Phase(), .captureIn(), .pinIn, .pinOut, .pinOe);
  pin_world outside (.pinOut, .pinOe, .extLevel(8'h5a), .pinIn);
  task wrap_up;
    begin
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [7:0] e);
    begin
      repeat (3) @(posedge clk);
      regAddr <= `ADDR_DATA;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      comparisons = comparisons + 1;
      if (regRdata !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] regRdata expected %h seen %h", e, regRdata);
      end
    end
  endtask
  // Select edges, load data, fire timers, read pins
  task step(input [7:0] sel, input [7:0] d, input [2:0] t, input [7:0] e);
    begin
      wr(`ADDR_EDGE_SEL, sel);
      wr(`ADDR_DATA, d);
      @(posedge clk);
      tmr <= t;
      repeat (2) @(posedge clk);
      tmr <= 3'h0;
      rd(e);
    end
  endtask
  initial begin
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h5a);
    wr(`ADDR_DRIVE_TYPE, 8'h00);
    wr(`ADDR_ALT_FUNC, 8'h00);
    wr(`ADDR_DATA, 8'h00);
    wr(`ADDR_DIRECTION, 8'hff);
    step(8'h21, 8'ha5, 3'h0, 8'h00);
    step(8'h21, 8'ha5, 3'h1, 8'h05);
    step(8'h21, 8'ha5, 3'h2, 8'ha5);
    step(8'h33, 8'h0f, 3'h3, 8'ha5);
    step(8'h33, 8'h0f, 3'h4, 8'h0f);
    step(8'h00, 8'h3c, 3'h0, 8'h3c);
    wr(`ADDR_DRIVE_TYPE, 8'hff);
    rd(8'h18);
    wr(`ADDR_DRIVE_TYPE, 8'h00);
    wr(`ADDR_ALT_FUNC, 8'hf0);
    rd(8'h9c);
    wr(`ADDR_ALT_FUNC, 8'h00);
    wr(`ADDR_DIRECTION, 8'h00);
    sMode <= 1'b1;
    sInt <= 1'b1;
    rd(8'h58);
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors = n_errors + 1;
    wrap_up;
  end
endmodule
